// ===== common/nws_pkg.sv
// shared constants and types for the nvm write/erase sequencer
package nws_pkg;
    // apb register byte offsets
    localparam logic [7:0] NWS_OFF_CTRL = 8'h00;
    localparam logic [7:0] NWS_OFF_KEY  = 8'h04;
    localparam logic [7:0] NWS_OFF_ADDR = 8'h08;
    localparam logic [7:0] NWS_OFF_DATA = 8'h0c;
    localparam logic [7:0] NWS_OFF_FLAG = 8'h10;
    localparam logic [7:0] NWS_OFF_IE   = 8'h14;
    // control register bit positions
    localparam int NWS_B_RD   = 0;
    localparam int NWS_B_WR   = 1;
    localparam int NWS_B_WEN   = 2;
    localparam int NWS_B_FREE  = 3;
    localparam int NWS_B_LATCH = 4;
    localparam int NWS_B_REGS = 6;
    // unlock keys
    localparam logic [7:0] NWS_KEY_FIRST  = 8'h55;
    localparam logic [7:0] NWS_KEY_SECOND = 8'haa;
    // widths
    localparam int NWS_AW = 15;
    localparam int NWS_DW = 14;
    localparam int NWS_TW = 16;
    localparam int NWS_BYTE = 8;
    // configuration-space map
    localparam logic [14:0] NWS_UID_LAST  = 15'h0003;
    localparam logic [14:0] NWS_ID_FIRST  = 15'h0005;
    localparam logic [14:0] NWS_ID_LAST   = 15'h0006;
    localparam logic [14:0] NWS_CW_FIRST  = 15'h0007;
    localparam logic [14:0] NWS_CW_LAST   = 15'h000b;
    localparam logic [14:0] NWS_INFO_FIRST = 15'h0100;
    localparam logic [14:0] NWS_INFO_LAST  = 15'h02ff;
    localparam logic [14:0] NWS_EE_FIRST  = 15'h7000;
    localparam logic [14:0] NWS_EE_LAST   = 15'h70ff;
    // row of 32 words: low address bits dropped on erase
    localparam int NWS_ROW_LSB = 5;
    // reset values
    localparam logic [14:0] NWS_ADDR_RST = 15'h0000;
    localparam logic [13:0] NWS_DATA_RST = 14'h0000;
    // timing: times in microseconds, counts in cycles of ref_clk_i
    localparam int NWS_CLK_MHZ      = 10;
    localparam int NWS_EE_WRITE_US  = 4000;
    localparam int NWS_ROW_ERASE_US = 2000;
    localparam int NWS_EE_WRITE_CYC  = NWS_EE_WRITE_US * NWS_CLK_MHZ;
    localparam int NWS_ROW_ERASE_CYC = NWS_ROW_ERASE_US * NWS_CLK_MHZ;
    // array operations
    typedef enum logic [1:0] {
        NWS_OP_READ,
        NWS_OP_EE_WRITE,
        NWS_OP_ROW_ERASE
    } nws_op_t;
    // command to the nvm array
    typedef struct packed {
        logic            valid;
        nws_op_t         op;
        logic            cfg;
        logic [14:0]     addr;
        logic [13:0]     wdata;
    } nws_mem_cmd_t;
    // access rights of one address
    typedef struct packed {
        logic rd_ok;
        logic wr_ok;
        logic erase_ok;
        logic is_ee;
    } nws_region_t;
endpackage

// ===== logic/nws_addr_decode.sv
// address map decoder for program and configuration space
`timescale 1ns/100ps
module nws_addr_decode
    import nws_pkg::*;
(
    // target selection
    input  wire logic              cfg_i,
    input  wire logic [NWS_AW-1:0] addr_i,
    // access rights
    output nws_region_t            region_o
);
    logic uid;
    logic ids;
    logic cw;
    logic info;
    logic ee;

    // reserved word 4 matches no range, so it neither reads nor writes
    always_comb begin
        uid = (addr_i <= NWS_UID_LAST);
        ids = (addr_i >= NWS_ID_FIRST) && (addr_i <= NWS_ID_LAST);
        cw  = (addr_i >= NWS_CW_FIRST) && (addr_i <= NWS_CW_LAST);
        info = (addr_i >= NWS_INFO_FIRST) && (addr_i <= NWS_INFO_LAST);
        ee  = (addr_i >= NWS_EE_FIRST) && (addr_i <= NWS_EE_LAST);
        if (!cfg_i) begin
            // whole 15-bit range is flash, vectors included  RL17
            region_o = '{rd_ok: 1'b1, wr_ok: 1'b1, erase_ok: 1'b1, is_ee: 1'b0};
        end else begin
            // RL18 RL23
            region_o.rd_ok    = uid | ids | cw | info | ee;
            region_o.wr_ok    = uid | cw | ee;
            region_o.erase_ok = uid;
            region_o.is_ee    = ee;
        end
    end
endmodule // nws_addr_decode

// ===== logic/nws_op_timer.sv
// one-shot cycle timer for array write and erase durations
`timescale 1ns/100ps
module nws_op_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // start with a count of at least one
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    // one-cycle pulse when the count runs out
    output logic              done_o
);
    logic [W-1:0] cnt_reg;
    logic         run_reg;

    // countdown; done is registered so it is glitch free
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                cnt_reg <= count_i;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg <= W'(1)) begin
                    run_reg <= 1'b0;
                    done_o  <= 1'b1;
                end
                cnt_reg <= cnt_reg - W'(1);
            end
        end
    end
endmodule // nws_op_timer

// ===== logic/nws_sequencer.sv
// nvm self-write sequencer: unlock keys, eeprom byte write, row erase, apb
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
// Behaviour
// RL1: keys 55h, AAh, then write start, in order
// RL2: any write with that effect counts
// RL3: software masks interrupts around the unlock
// RL4: write enable must be set to start
// RL5: eeprom write: config space, enable, 0x7000 range
// RL6: eeprom write stores one byte from data
// RL7: eeprom byte is erased implicitly first
// RL8: cpu keeps running during eeprom write
// RL9: end clears start bit, sets done flag
// RL10: software polls start bit or waits interrupt
// RL11: clearing start bit mid eeprom write ignored
// RL12: row erase setup by software, then unlock
// RL13: flash erased per row, never implicitly
// RL14: protected row erase clears start, no erase
// RL15: row erase stalls cpu, then sets flag
// RL16: erase keeps latches and write enable
// RL17: program space spans 0x0000 to 0x7fff
// RL18: configuration space map with access rights
// RL19: writes blocked while target protected
// RL20: broken unlock starts nothing
// RL21: invalid config read clears data pair
// RL22: wrong or misordered key resets tracker
// RL23: reserved config word 4 inert, reads zero
module nws_sequencer
    import nws_pkg::*;
#(
    parameter logic [NWS_TW-1:0] EE_WRITE_CYC  = NWS_TW'(NWS_EE_WRITE_CYC),
    parameter logic [NWS_TW-1:0] ROW_ERASE_CYC = NWS_TW'(NWS_ROW_ERASE_CYC)
) (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // write protection of the current target
    input  wire logic              wr_protect_i,
    // nvm array
    output nws_mem_cmd_t           mem_cmd_o,
    input  wire logic [NWS_DW-1:0] mem_rdata_i,
    // cpu side
    output logic                   cpu_stall_o,
    output logic                   nvm_irq_o
);
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ONE,
        KEY_TWO
    } nws_key_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_EE_BUSY,
        ST_ERASE_BUSY
    } nws_state_t;

    nws_key_t          key_reg;
    nws_state_t        st_reg;
    logic              rd_reg;
    logic              wr_reg;
    logic              wen_reg;
    logic              free_reg;
    logic              latch_reg;
    logic              regs_reg;
    logic [NWS_AW-1:0] addr_reg;
    logic [NWS_DW-1:0] data_reg;
    logic              flag_reg;
    logic              ie_reg;
    logic              tmr_done;
    nws_region_t       region;
    logic              sel_cfg;
    logic              wr_acc;
    logic              acc_start;
    logic              ctrl_wr;
    logic              key_wr;
    logic              go;
    logic              ee_go;
    logic              erase_go;
    logic              rd_go;
    logic              rd_bad;
    logic              ctrl_clr_wr;
    logic [31:0]       rdata_next;
    logic              mapped;

    // ---------------- apb decode ----------------
    // one wait state: pready rises in the second access cycle
    assign acc_start   = psel_i & penable_i & ~pready_o;
    assign wr_acc      = psel_i & penable_i & pready_o & pwrite_i;
    assign ctrl_wr     = wr_acc & (paddr_i == NWS_OFF_CTRL);
    assign key_wr      = wr_acc & (paddr_i == NWS_OFF_KEY);
    assign ctrl_clr_wr = ctrl_wr & ~pwdata_i[NWS_B_WR];

    // the control write that sets start may also change the space select
    assign sel_cfg = ctrl_wr ? pwdata_i[NWS_B_REGS] : regs_reg;

    nws_addr_decode u_decode (
        .cfg_i    (sel_cfg),
        .addr_i   (addr_reg),
        .region_o (region)
    );

    // start request: armed tracker plus enabled write of the start bit
    assign go = ctrl_wr & pwdata_i[NWS_B_WR] & pwdata_i[NWS_B_WEN] // RL4
              & (key_reg == KEY_TWO) & (st_reg == ST_IDLE); // RL1 RL20
    // byte write with built-in erase; latch-only mode is not served here
    assign ee_go = go & ~pwdata_i[NWS_B_FREE] & ~pwdata_i[NWS_B_LATCH]
                 & region.is_ee & ~wr_protect_i; // RL5 RL7 RL19
    // erase only on request, only rows, only unprotected  RL13
    assign erase_go = go & pwdata_i[NWS_B_FREE] & region.erase_ok
                    & ~wr_protect_i; // RL14 RL19
    assign rd_go  = ctrl_wr & pwdata_i[NWS_B_RD] & (st_reg == ST_IDLE);
    assign rd_bad = sel_cfg & ~region.rd_ok; // RL21 RL23

    // ---------------- unlock tracker ----------------
    // any bus write with the register effect counts, whatever made it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            key_reg <= KEY_IDLE;
        end else if (key_wr) begin // RL2
            if (pwdata_i[7:0] == NWS_KEY_FIRST) begin
                key_reg <= KEY_ONE;
            end else if (pwdata_i[7:0] == NWS_KEY_SECOND && key_reg == KEY_ONE) begin
                key_reg <= KEY_TWO;
            end else begin
                key_reg <= KEY_IDLE; // RL22
            end
        end else if (wr_acc) begin
            // any other write in between breaks the sequence  RL1 RL22
            key_reg <= KEY_IDLE;
        end
    end

    // ---------------- control register ----------------
    // start and read bits are owned by the state machine while busy
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wen_reg   <= 1'b0;
            free_reg  <= 1'b0;
            latch_reg <= 1'b0;
            regs_reg  <= 1'b0;
        end else if (ctrl_wr) begin
            // hardware never touches write enable  RL16
            wen_reg   <= pwdata_i[NWS_B_WEN];
            free_reg  <= pwdata_i[NWS_B_FREE];
            latch_reg <= pwdata_i[NWS_B_LATCH];
            regs_reg <= pwdata_i[NWS_B_REGS];
        end
    end

    // start bit: set only by a real start, cleared at completion
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg <= 1'b0;
        end else if (st_reg != ST_IDLE) begin
            // a software clear mid-operation has no effect  RL11
            if (tmr_done) begin
                wr_reg <= 1'b0; // RL9 RL15
            end
        end else begin
            // a refused start leaves the bit clear  RL14
            wr_reg <= ee_go | erase_go;
        end
    end

    // address pair
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_reg <= NWS_ADDR_RST;
        end else if (wr_acc && paddr_i == NWS_OFF_ADDR && st_reg == ST_IDLE) begin
            addr_reg <= pwdata_i[NWS_AW-1:0];
        end
    end

    // data pair: software writes, array reads, invalid reads clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_reg <= NWS_DATA_RST;
        end else if (st_reg == ST_READ) begin
            data_reg <= mem_rdata_i;
        end else if (rd_go && rd_bad) begin
            data_reg <= NWS_DATA_RST; // RL21
        end else if (wr_acc && paddr_i == NWS_OFF_DATA && st_reg == ST_IDLE) begin
            data_reg <= pwdata_i[NWS_DW-1:0];
        end
    end

    // ---------------- operation state machine ----------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= ST_IDLE;
            rd_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (ee_go) begin
                        st_reg <= ST_EE_BUSY;
                    end else if (erase_go) begin
                        st_reg <= ST_ERASE_BUSY;
                    end else if (rd_go && !rd_bad) begin
                        st_reg <= ST_READ;
                        rd_reg <= 1'b1;
                    end
                end
                ST_READ: begin
                    st_reg <= ST_IDLE;
                    rd_reg <= 1'b0;
                end
                ST_EE_BUSY, ST_ERASE_BUSY: begin
                    if (tmr_done) begin
                        st_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // cpu stall: reads and row erase halt the core, eeprom writes do not
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_stall_o <= 1'b0;
        end else if (st_reg == ST_IDLE) begin
            cpu_stall_o <= erase_go | (rd_go & ~rd_bad & ~ee_go); // RL15 RL8
        end else if (st_reg == ST_READ || tmr_done) begin
            cpu_stall_o <= 1'b0;
        end
    end

    // duration of the array operation
    nws_op_timer #(
        .W (NWS_TW)
    ) u_timer (
        .clk_i   (ref_clk_i),
        .rst_i   (rst_i),
        .load_i  (ee_go | erase_go),
        .count_i (ee_go ? EE_WRITE_CYC : ROW_ERASE_CYC),
        .done_o  (tmr_done)
    );

    // one-cycle command to the array; erase carries the row base only
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_cmd_o <= '0;
        end else begin
            mem_cmd_o.valid <= 1'b0;
            if (ee_go) begin
                mem_cmd_o.valid <= 1'b1;
                mem_cmd_o.op    <= NWS_OP_EE_WRITE; // RL7
                mem_cmd_o.cfg   <= 1'b1;
                mem_cmd_o.addr  <= addr_reg;
                mem_cmd_o.wdata <= {{(NWS_DW-NWS_BYTE){1'b0}}, data_reg[NWS_BYTE-1:0]}; // RL6
            end else if (erase_go) begin
                mem_cmd_o.valid <= 1'b1;
                mem_cmd_o.op    <= NWS_OP_ROW_ERASE; // RL13
                mem_cmd_o.cfg   <= sel_cfg;
                mem_cmd_o.addr  <= {addr_reg[NWS_AW-1:NWS_ROW_LSB], {NWS_ROW_LSB{1'b0}}};
                mem_cmd_o.wdata <= '0;
            end else if (st_reg == ST_IDLE && rd_go && !rd_bad) begin
                mem_cmd_o.valid <= 1'b1;
                mem_cmd_o.op    <= NWS_OP_READ;
                mem_cmd_o.cfg   <= sel_cfg;
                mem_cmd_o.addr  <= addr_reg;
                mem_cmd_o.wdata <= '0;
            end
        end
    end

    // ---------------- completion flag and interrupt ----------------
    // completion beats a same-cycle write-one-to-clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else if (tmr_done) begin
            flag_reg <= 1'b1; // RL9 RL15
        end else if (wr_acc && paddr_i == NWS_OFF_FLAG && pwdata_i[0]) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ie_reg <= 1'b0;
        end else if (wr_acc && paddr_i == NWS_OFF_IE) begin
            ie_reg <= pwdata_i[0];
        end
    end

    // request is a level, one cycle behind the flag
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nvm_irq_o <= 1'b0;
        end else begin
            nvm_irq_o <= flag_reg & ie_reg; // RL9
        end
    end

    // ---------------- apb read and answer ----------------
    always_comb begin
        rdata_next = '0;
        mapped     = 1'b1;
        unique case (paddr_i)
            NWS_OFF_CTRL: begin
                rdata_next[NWS_B_RD]   = rd_reg;
                rdata_next[NWS_B_WR]   = wr_reg;
                rdata_next[NWS_B_WEN]   = wen_reg;
                rdata_next[NWS_B_FREE]  = free_reg;
                rdata_next[NWS_B_LATCH] = latch_reg;
                rdata_next[NWS_B_REGS] = regs_reg;
            end
            NWS_OFF_KEY:  rdata_next = '0;
            NWS_OFF_ADDR: rdata_next[NWS_AW-1:0] = addr_reg;
            NWS_OFF_DATA: rdata_next[NWS_DW-1:0] = data_reg;
            NWS_OFF_FLAG: rdata_next[0] = flag_reg;
            NWS_OFF_IE:   rdata_next[0] = ie_reg;
            default:      mapped = 1'b0;
        endcase
    end

    // answer registered in the first access cycle, dropped after
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= acc_start;
            pslverr_o <= acc_start & ~mapped;
            prdata_o  <= (acc_start & ~pwrite_i) ? rdata_next : '0;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_key_bad_reset: assert property (key_wr && pwdata_i[7:0] != NWS_KEY_FIRST
        && !(pwdata_i[7:0] == NWS_KEY_SECOND && key_reg == KEY_ONE)
        |=> key_reg == KEY_IDLE) else $error("bad key did not reset tracker"); // RL22
    a_no_start_unarmed: assert property (ctrl_wr && key_reg != KEY_TWO && st_reg == ST_IDLE
        |=> !wr_reg && st_reg != ST_EE_BUSY && st_reg != ST_ERASE_BUSY)
        else $error("start without unlock"); // RL20
    a_done_flag_set: assert property (st_reg == ST_EE_BUSY && tmr_done
        |=> !wr_reg && flag_reg && st_reg == ST_IDLE) else $error("completion missed"); // RL9
    a_ee_no_stall: assert property (st_reg == ST_EE_BUSY |-> !cpu_stall_o)
        else $error("eeprom write stalled cpu"); // RL8
    a_erase_stall: assert property ($rose(st_reg == ST_ERASE_BUSY)
        |-> cpu_stall_o ##1 (cpu_stall_o throughout (st_reg == ST_ERASE_BUSY)[*1]))
        else $error("row erase did not stall"); // RL15
    a_wr_clear_held: assert property (st_reg == ST_EE_BUSY && ctrl_clr_wr && !tmr_done
        |=> wr_reg && st_reg == ST_EE_BUSY) else $error("start bit clear honoured"); // RL11
    a_prot_blocks: assert property (go && wr_protect_i
        |=> !wr_reg && !mem_cmd_o.valid) else $error("protected target written"); // RL14
    a_bad_read_zero: assert property (rd_go && rd_bad
        |=> data_reg == NWS_DATA_RST && !mem_cmd_o.valid) else $error("bad read kept data"); // RL21
    a_wen_kept: assert property (tmr_done && !ctrl_wr
        |=> wen_reg == $past(wen_reg)) else $error("write enable changed"); // RL16
    a_ee_byte_only: assert property (ee_go |=> mem_cmd_o.valid
        && mem_cmd_o.wdata[NWS_DW-1:NWS_BYTE] == '0) else $error("eeprom not one byte"); // RL6

    c_ee_write: cover property (st_reg == ST_EE_BUSY && tmr_done);
    c_row_erase: cover property (erase_go);
    c_bad_read: cover property (rd_go && rd_bad);
    c_key_broken: cover property (key_reg == KEY_ONE ##1 key_reg == KEY_IDLE);
endmodule // nws_sequencer

// ===== verification/nvm_write_erase_sequencer_test.sv
// self-checking testbench for the nvm write/erase sequencer
`timescale 1ns/100ps
module nvm_write_erase_sequencer_test;
    import nws_pkg::*;
    logic              ref_clk_i = 1'b0;
    logic              rst_i     = 1'b1;
    logic              psel = 1'b0, pen = 1'b0, pwr = 1'b0, prot = 1'b0;
    logic [7:0]        pa  = 8'h00;
    logic [31:0]       pwd = 32'h0, rd, prdata;
    logic              pready, perr, stall, irq, errf;
    logic [NWS_DW-1:0] mrd;
    nws_mem_cmd_t      cmd, last;
    int                n_cmd, n0, n_mismatch = 0, compares = 0, cyc = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    // short write time so the start bit can be seen standing while software pokes it
    nws_sequencer #(.EE_WRITE_CYC(16'd12), .ROW_ERASE_CYC(16'd5)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .wr_protect_i(prot), .mem_cmd_o(cmd),
        .mem_rdata_i(mrd), .cpu_stall_o(stall), .nvm_irq_o(irq));
    nws_nvm_model mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_i(cmd), .rdata_o(mrd),
        .last_o(last), .n_cmd_o(n_cmd));

    task automatic complete_run;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer: setup, access held until pready is sampled high
    // no fixed wait is assumed: only the hang guard ends a stuck access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
        @(posedge ref_clk_i);
        pen <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd = prdata;
        errf = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // interrupts are assumed masked by software around this
    task automatic unlock(input logic [31:0] c);
        wr(NWS_OFF_KEY, 32'h55); wr(NWS_OFF_KEY, 32'haa); wr(NWS_OFF_CTRL, c);
    endtask
    // software polls the start bit, bounded
    task automatic wait_idle;
        int i;
        for (i = 0; i < 40; i++) begin
            apb(1'b0, NWS_OFF_CTRL, 32'h0);
            if (rd[1] === 1'b0) break;
        end
    endtask

    task automatic t_reset;
        rchk(NWS_OFF_CTRL, 32'h5f, 32'h0);
        rchk(NWS_OFF_ADDR, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, errf}, 32'h1);
    endtask
    task automatic t_ee_write;
        wr(NWS_OFF_IE, 32'h1); wr(NWS_OFF_CTRL, 32'h44);
        wr(NWS_OFF_ADDR, 32'h7003); wr(NWS_OFF_DATA, 32'h3fa5); n0 = n_cmd;
        unlock(32'h46);
        @(posedge ref_clk_i); #1;
        chk({31'h0, stall}, 32'h0);
        chk(32'({last.op, last.cfg, last.addr}), 32'({NWS_OP_EE_WRITE, 1'b1, 15'h7003}));
        chk(32'(last.wdata), 32'ha5);
        wr(NWS_OFF_CTRL, 32'h44); rchk(NWS_OFF_CTRL, 32'h06, 32'h06);
        wait_idle; chk(rd & 32'h46, 32'h44);
        rchk(NWS_OFF_FLAG, 32'h1, 32'h1); chk({31'h0, irq}, 32'h1);
        chk(32'(n_cmd - n0), 32'h1);
    endtask
    task automatic t_broken;
        n0 = n_cmd;
        wr(NWS_OFF_KEY, 32'h55); wr(NWS_OFF_KEY, 32'h12); wr(NWS_OFF_CTRL, 32'h46);
        wr(NWS_OFF_KEY, 32'h55); wr(NWS_OFF_KEY, 32'haa); wr(NWS_OFF_DATA, 32'h1);
        wr(NWS_OFF_CTRL, 32'h46);
        unlock(32'h42);
        unlock(32'h56);
        wr(NWS_OFF_CTRL, 32'h44); wr(NWS_OFF_ADDR, 32'h0007); unlock(32'h46);
        rchk(NWS_OFF_CTRL, 32'h2, 32'h0); chk(32'(n_cmd - n0), 32'h0);
    endtask
    task automatic t_erase;
        wr(NWS_OFF_FLAG, 32'h1); rchk(NWS_OFF_FLAG, 32'h1, 32'h0); chk({31'h0, irq}, 32'h0);
        wr(NWS_OFF_CTRL, 32'h0c); wr(NWS_OFF_ADDR, 32'h7ff4); unlock(32'h0e);
        @(posedge ref_clk_i); #1;
        chk({31'h0, stall}, 32'h1);
        chk(32'({last.op, last.addr}), 32'({NWS_OP_ROW_ERASE, 15'h7fe0}));
        wait_idle; chk(rd & 32'h0e, 32'h0c);
        chk({31'h0, stall}, 32'h0); rchk(NWS_OFF_FLAG, 32'h1, 32'h1);
        prot <= 1'b1; n0 = n_cmd;
        unlock(32'h0e); rchk(NWS_OFF_CTRL, 32'h2, 32'h0);
        chk(32'(n_cmd - n0), 32'h0); prot <= 1'b0;
    endtask
    task automatic t_read;
        wr(NWS_OFF_DATA, 32'h3fff); wr(NWS_OFF_CTRL, 32'h40); wr(NWS_OFF_ADDR, 32'h0004);
        wr(NWS_OFF_CTRL, 32'h41); rchk(NWS_OFF_DATA, 32'hffffffff, 32'h0);
        wr(NWS_OFF_ADDR, 32'h0002); wr(NWS_OFF_CTRL, 32'h41);
        rchk(NWS_OFF_DATA, 32'h3fff, 32'(14'h0002 ^ 14'h2a5a));
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run;
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_ee_write;
        t_broken;
        t_erase;
        t_read;
        complete_run;
    end
endmodule // nvm_write_erase_sequencer_test

// ===== verification/nws_nvm_model.sv
// behavioural nvm array facing the sequencer's memory command port
`timescale 1ns/100ps
module nws_nvm_model
    import nws_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // command from the sequencer
    input  wire nws_mem_cmd_t      cmd_i,
    output logic [NWS_DW-1:0]      rdata_o,
    // observation for the bench
    output nws_mem_cmd_t           last_o,
    output int                     n_cmd_o
);
    logic [NWS_DW-1:0] churn_reg;
    // record every command; churn keeps idle read data moving so stale values never match
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_o    <= '0;
            n_cmd_o   <= 0;
            churn_reg <= 14'h1555;
        end else begin
            churn_reg <= ~churn_reg + 14'h0001;
            if (cmd_i.valid) begin
                last_o  <= cmd_i;
                n_cmd_o <= n_cmd_o + 1;
            end
        end
    end
    // read data only valid in the command cycle, derived from the address
    assign rdata_o = (cmd_i.valid && cmd_i.op == NWS_OP_READ) ? (cmd_i.addr[13:0] ^ 14'h2a5a)
                                                              : churn_reg;
endmodule // nws_nvm_model
